// File: logic/dbg_trace_pkg.sv
package dbg_trace_pkg;

  typedef enum logic [1:0] {
    CMD_NOP = 2'h0,
    CMD_CALL = 2'h1,
    CMD_RST = 2'h2,
    CMD_ILLEGAL = 2'h3
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STACK = 3'b001,
    ST_FIRST = 3'b010,
    ST_RSTHOLD = 3'b011,
    ST_RSTREL = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic [15:0] opcode;
    logic [31:0] operand;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic berr;
    logic aerr;
    logic [15:0] word;
  } fetch_done_t;

endpackage

// File: logic/dbg_trace_regs.svh
`ifndef DBG_TRACE_REGS_SVH
`define DBG_TRACE_REGS_SVH

// Debug command opcodes served by this block.
`define DBG_OP_CALL 16'h0C80
`define DBG_OP_RST 16'h0C40
`define DBG_OP_NOP 16'h0000

// Serial shifter responses, 17 bits with the status bit on top.
`define DBG_RESP_COMPLETE 17'h0FFFF
`define DBG_RESP_ILLEGAL 17'h1FFFF
`define DBG_RESP_BUS_ERR 17'h10001

// Peripheral reset hold time in clock cycles.
`define DBG_RST_HOLD_CYCLES 512

// Indication lengths in clocks on the tracking pins.
`define DBG_LEN_FETCH 2'h1
`define DBG_LEN_FLUSH 2'h2
`define DBG_LEN_EXT 2'h1
`define DBG_LEN_START 2'h2

`endif

// File: logic/debug_cmd_and_pipe_trace.sv
`include "dbg_trace_regs.svh"
`timescale 1ns/1ps
module debug_cmd_and_pipe_trace
  import dbg_trace_pkg::*;
#(
  parameter int RST_HOLD = `DBG_RST_HOLD_CYCLES,
  parameter int WORD_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic DEBUG_ENTER,
  output logic HALTED,
  input wire logic CMD_VALID,
  input wire cmd_req_t CMD_REQ,
  output logic CMD_READY,
  output logic RESP_VALID,
  output logic [16:0] RESP_DATA,
  input wire logic [31:0] RPC_IN,
  input wire logic [31:0] SP_IN,
  output logic STACK_REQ,
  output logic [31:0] STACK_ADDR,
  output logic [31:0] STACK_DATA,
  input wire logic STACK_DONE,
  input wire logic STACK_ERR,
  output logic PC_LOAD,
  output logic [31:0] PC_VALUE,
  output logic EXC_REQ,
  output logic EXC_ADDR_ERR,
  output logic [31:0] EXC_FAULT_ADDR,
  output logic SYS_RESET_N,
  input wire logic FLUSH,
  input wire logic FETCH_CYCLE,
  input wire fetch_done_t FETCH_DONE,
  input wire logic ADV_EXT,
  input wire logic INSN_START,
  input wire logic LOOP_RECIRC,
  output logic FETCH_IND_N,
  output logic PIPE_ADV_N,
  output logic [WORD_W-1:0] DECODE_WORD,
  output logic DECODE_VALID,
  output logic [WORD_W-1:0] EXEC_WORD,
  output logic EXEC_VALID,
  output logic PREFETCH_ROOM
);

  function automatic cmd_t classify(input logic [15:0] op);
    if (op == `DBG_OP_CALL) begin
      return CMD_CALL;
    end else if (op == `DBG_OP_RST) begin
      return CMD_RST;
    end else if (op == `DBG_OP_NOP) begin
      return CMD_NOP;
    end else begin
      return CMD_ILLEGAL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // Command sequencer.

  seq_state_t state_r, state_nxt;
  logic halted_r;
  logic resp_valid_r;
  logic [16:0] resp_data_r;
  logic stack_req_r;
  logic [31:0] stack_addr_r;
  logic [31:0] stack_data_r;
  logic [31:0] pc_r;
  logic pc_load_r;
  logic exc_req_r;
  logic exc_aerr_r;
  logic [31:0] exc_addr_r;
  logic sys_reset_n_r;
  logic [9:0] rst_cnt_r;

  wire logic cmd_take = CMD_VALID && CMD_READY;
  wire cmd_t cmd_kind = classify(CMD_REQ.opcode);
  wire logic stack_ok = (state_r == ST_STACK) && STACK_DONE && !STACK_ERR;
  wire logic stack_bad = (state_r == ST_STACK) && STACK_DONE && STACK_ERR;
  wire logic first_done = (state_r == ST_FIRST) && FETCH_DONE.valid;
  wire logic first_bad = first_done && (FETCH_DONE.berr || FETCH_DONE.aerr);
  wire logic rst_last = (state_r == ST_RSTHOLD) && (rst_cnt_r == 10'(RST_HOLD - 1));

  assign CMD_READY = halted_r && (state_r == ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_take && cmd_kind == CMD_CALL) begin
          state_nxt = ST_STACK;
        end else if (cmd_take && cmd_kind == CMD_RST) begin
          state_nxt = ST_RSTHOLD;
        end
      end
      ST_STACK: begin
        if (stack_ok) begin
          state_nxt = ST_FIRST;
        end else if (stack_bad) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FIRST: begin
        if (first_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RSTHOLD: begin
        if (rst_last) begin
          state_nxt = ST_RSTREL;
        end
      end
      ST_RSTREL: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // The response word is held until the next response replaces it, as a shifter would.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      resp_valid_r <= 1'b0;
      resp_data_r <= `DBG_RESP_COMPLETE;
    end else begin
      state_r <= state_nxt;
      resp_valid_r <= 1'b0;
      if (cmd_take && cmd_kind == CMD_NOP) begin
        resp_valid_r <= 1'b1;
        resp_data_r <= `DBG_RESP_COMPLETE;
      end else if (cmd_take && cmd_kind == CMD_ILLEGAL) begin
        resp_valid_r <= 1'b1;
        resp_data_r <= `DBG_RESP_ILLEGAL;
      end else if (stack_bad) begin
        resp_valid_r <= 1'b1;
        resp_data_r <= `DBG_RESP_BUS_ERR;
      end else if (state_r == ST_RSTREL) begin
        resp_valid_r <= 1'b1;
        resp_data_r <= `DBG_RESP_COMPLETE;
      end
    end
  end

  // Halt is left only after the return address is safely on the stack.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      halted_r <= 1'b0;
    end else if (DEBUG_ENTER) begin
      halted_r <= 1'b1;
    end else if (stack_ok) begin
      halted_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stack_req_r <= 1'b0;
      stack_addr_r <= 32'h0000_0000;
      stack_data_r <= 32'h0000_0000;
      pc_r <= 32'h0000_0000;
    end else if (cmd_take && cmd_kind == CMD_CALL) begin
      stack_req_r <= 1'b1;
      stack_addr_r <= SP_IN;
      stack_data_r <= RPC_IN;
      pc_r <= CMD_REQ.operand;
    end else if (state_r == ST_STACK && STACK_DONE) begin
      stack_req_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_load_r <= 1'b0;
      exc_req_r <= 1'b0;
      exc_aerr_r <= 1'b0;
      exc_addr_r <= 32'h0000_0000;
    end else begin
      pc_load_r <= stack_ok;
      exc_req_r <= first_bad;
      if (first_bad) begin
        exc_aerr_r <= FETCH_DONE.aerr;
        exc_addr_r <= pc_r;
      end
    end
  end

  // The processor stays halted while the peripherals sit in reset.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sys_reset_n_r <= 1'b1;
      rst_cnt_r <= 10'h000;
    end else if (cmd_take && cmd_kind == CMD_RST) begin
      sys_reset_n_r <= 1'b0;
      rst_cnt_r <= 10'h000;
    end else if (rst_last) begin
      sys_reset_n_r <= 1'b1;
    end else if (state_r == ST_RSTHOLD) begin
      rst_cnt_r <= rst_cnt_r + 10'h001;
    end
  end

  assign HALTED = halted_r;
  assign RESP_VALID = resp_valid_r;
  assign RESP_DATA = resp_data_r;
  assign STACK_REQ = stack_req_r;
  assign STACK_ADDR = stack_addr_r;
  assign STACK_DATA = stack_data_r;
  assign PC_LOAD = pc_load_r;
  assign PC_VALUE = pc_r;
  assign EXC_REQ = exc_req_r;
  assign EXC_ADDR_ERR = exc_aerr_r;
  assign EXC_FAULT_ADDR = exc_addr_r;
  assign SYS_RESET_N = sys_reset_n_r;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Opcode tracking.

  logic flush_pend_r;
  logic adv_one_pend_r;

  wire logic pipe_flush = FLUSH || pc_load_r;
  wire logic fetch_shown = FETCH_CYCLE && !LOOP_RECIRC;
  wire logic [1:0] fetch_len = flush_pend_r ? `DBG_LEN_FLUSH : `DBG_LEN_FETCH;
  wire logic both_adv = INSN_START && ADV_EXT;
  wire logic adv_req = INSN_START || ADV_EXT;
  wire logic [1:0] adv_len = both_adv ? (`DBG_LEN_START + `DBG_LEN_EXT)
                                      : (INSN_START ? `DBG_LEN_START : `DBG_LEN_EXT);
  wire logic adv_one = (ADV_EXT && !INSN_START) || adv_one_pend_r;
  wire logic word_in = FETCH_DONE.valid && !FETCH_DONE.berr && !FETCH_DONE.aerr;

  // A flush arriving with a fetch wins, so the next fetch still reports the refill.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flush_pend_r <= 1'b0;
      adv_one_pend_r <= 1'b0;
    end else begin
      if (pipe_flush) begin
        flush_pend_r <= 1'b1;
      end else if (fetch_shown) begin
        flush_pend_r <= 1'b0;
      end
      adv_one_pend_r <= both_adv;
    end
  end

  trace_pin_encoder #(.CW(3)) u_fetch_pin (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .req(fetch_shown),
    .req_len(fetch_len),
    .pin_n(FETCH_IND_N)
  );

  trace_pin_encoder #(.CW(3)) u_adv_pin (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .req(adv_req),
    .req_len(adv_len),
    .pin_n(PIPE_ADV_N)
  );

  pipe_stages #(.W(WORD_W)) u_pipe (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(pipe_flush),
    .load(word_in),
    .load_word(FETCH_DONE.word),
    .adv_one(adv_one),
    .adv_full(INSN_START),
    .dec_word(DECODE_WORD),
    .dec_valid(DECODE_VALID),
    .exe_word(EXEC_WORD),
    .exe_valid(EXEC_VALID),
    .room(PREFETCH_ROOM)
  );

endmodule

// File: logic/pipe_stages.sv
`timescale 1ns/1ps
module pipe_stages
  import dbg_trace_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic load,
  input wire logic [W-1:0] load_word,
  input wire logic adv_one,
  input wire logic adv_full,
  output logic [W-1:0] dec_word,
  output logic dec_valid,
  output logic [W-1:0] exe_word,
  output logic exe_valid,
  output logic room
);

  logic [W-1:0] buf_r, dec_r, exe_r;
  logic buf_v_r, dec_v_r, exe_v_r;
  logic [W-1:0] buf_nxt, dec_nxt, exe_nxt;
  logic buf_v_nxt, dec_v_nxt, exe_v_nxt;

  always_comb begin
    buf_nxt = buf_r;
    dec_nxt = dec_r;
    exe_nxt = exe_r;
    buf_v_nxt = buf_v_r;
    dec_v_nxt = dec_v_r;
    exe_v_nxt = exe_v_r;
    if (adv_full) begin
      exe_nxt = dec_nxt;
      exe_v_nxt = dec_v_nxt;
      dec_v_nxt = 1'b0;
    end else if (adv_one) begin
      dec_v_nxt = 1'b0;
    end
    if (exe_v_nxt == 1'b0 && dec_v_nxt) begin
      exe_nxt = dec_nxt;
      exe_v_nxt = 1'b1;
      dec_v_nxt = 1'b0;
    end
    if (dec_v_nxt == 1'b0 && buf_v_nxt) begin
      dec_nxt = buf_nxt;
      dec_v_nxt = 1'b1;
      buf_v_nxt = 1'b0;
    end
    if (load && !buf_v_nxt) begin
      buf_nxt = load_word;
      buf_v_nxt = 1'b1;
    end
    if (flush) begin
      buf_v_nxt = 1'b0;
      dec_v_nxt = 1'b0;
      exe_v_nxt = 1'b0;
    end
  end

  assign dec_word = dec_r;
  assign dec_valid = dec_v_r;
  assign exe_word = exe_r;
  assign exe_valid = exe_v_r;
  assign room = !buf_v_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= '0;
      dec_r <= '0;
      exe_r <= '0;
      buf_v_r <= 1'b0;
      dec_v_r <= 1'b0;
      exe_v_r <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
      dec_r <= dec_nxt;
      exe_r <= exe_nxt;
      buf_v_r <= buf_v_nxt;
      dec_v_r <= dec_v_nxt;
      exe_v_r <= exe_v_nxt;
    end
  end

endmodule

// File: logic/trace_pin_encoder.sv
`timescale 1ns/1ps
module trace_pin_encoder
  import dbg_trace_pkg::*;
#(
  parameter int CW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [1:0] req_len,
  output logic pin_n
);

  // Indications that arrive while the pin is still low extend it without a gap.
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic pin_n_r;
  wire logic [CW-1:0] cnt_left = (cnt_r != '0) ? cnt_r - {{(CW-1){1'b0}}, 1'b1} : cnt_r;
  wire logic [CW-1:0] add_len = req ? {{(CW-2){1'b0}}, req_len} : '0;

  assign cnt_nxt = cnt_left + add_len;
  assign pin_n = pin_n_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      pin_n_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      pin_n_r <= (cnt_nxt == '0);
    end
  end

endmodule

// File: verification/core_stack_model.sv
`timescale 1ns/1ps
module core_stack_model (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic STACK_REQ,
  input wire logic fail,
  input wire logic [3:0] lag,
  output logic STACK_DONE,
  output logic STACK_ERR
);
  logic [3:0] wait_r;
  // Outside a done pulse the error line toggles, so it only counts beside done.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_r <= 4'h0;
      STACK_DONE <= 1'b0;
      STACK_ERR <= 1'b0;
    end else if (STACK_REQ && !STACK_DONE && wait_r >= lag) begin
      wait_r <= 4'h0;
      STACK_DONE <= 1'b1;
      STACK_ERR <= fail;
    end else begin
      wait_r <= STACK_REQ ? wait_r + 4'h1 : 4'h0;
      STACK_DONE <= 1'b0;
      STACK_ERR <= ~STACK_ERR;
    end
  end
endmodule

// File: verification/dbg_trace_chk_assertions.sv
`timescale 1ns/1ps
module dbg_trace_chk
  import dbg_trace_pkg::*;
#(
  parameter int RST_HOLD = 512
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire cmd_req_t CMD_REQ,
  input wire logic CMD_READY,
  input wire logic RESP_VALID,
  input wire logic [16:0] RESP_DATA,
  input wire logic STACK_REQ,
  input wire logic STACK_DONE,
  input wire logic STACK_ERR,
  input wire logic HALTED,
  input wire logic PC_LOAD,
  input wire logic SYS_RESET_N,
  input wire logic FLUSH,
  input wire logic FETCH_CYCLE,
  input wire logic LOOP_RECIRC,
  input wire logic FETCH_IND_N,
  input wire logic ADV_EXT,
  input wire logic INSN_START,
  input wire logic PIPE_ADV_N
);
  logic take;
  logic [15:0] op;
  logic [15:0] low_cnt_r;
  assign take = CMD_VALID && CMD_READY;
  assign op = CMD_REQ.opcode;
  // A counter measures the reset width; a repetition of 512 would choke the tools.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= SYS_RESET_N ? 16'h0000 : low_cnt_r + 16'h0001;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  chk_nop_done: assert property (
    take && op == 16'h0000 |=> RESP_VALID && RESP_DATA == 17'h0FFFF)
    else $error("no-op response wrong");
  chk_illegal_resp: assert property (
    take && !(op inside {16'h0000, 16'h0C40, 16'h0C80}) |=> RESP_VALID && RESP_DATA == 17'h1FFFF)
    else $error("unassigned opcode response wrong");
  chk_reset_width: assert property (
    $rose(SYS_RESET_N) |-> low_cnt_r == RST_HOLD)
    else $error("peripheral reset width wrong");
  chk_reset_done: assert property (
    $rose(SYS_RESET_N) |=> RESP_VALID && RESP_DATA == 17'h0FFFF)
    else $error("reset completion response missing");
  chk_stack_err: assert property (
    STACK_REQ && STACK_DONE && STACK_ERR |=> RESP_VALID && RESP_DATA == 17'h10001 && HALTED)
    else $error("stack error not reported");
  chk_call_jump: assert property (
    STACK_REQ && STACK_DONE && !STACK_ERR |=> PC_LOAD && !HALTED)
    else $error("call did not jump");
  chk_fetch_cause: assert property (
    $fell(FETCH_IND_N) |-> $past(FETCH_CYCLE) && !$past(LOOP_RECIRC))
    else $error("fetch indicator without fetch");
  chk_flush_fetch: assert property (
    FLUSH ##1 FETCH_CYCLE && !LOOP_RECIRC |=> !FETCH_IND_N [*2])
    else $error("flush fetch too short");
  chk_adv_cause: assert property (
    $fell(PIPE_ADV_N) |-> $past(ADV_EXT) || $past(INSN_START))
    else $error("advance pin without cause");
  chk_ext_single: assert property (
    ADV_EXT && !INSN_START && PIPE_ADV_N && !$past(ADV_EXT) && !$past(INSN_START)
    ##1 !ADV_EXT && !INSN_START |-> !PIPE_ADV_N ##1 PIPE_ADV_N)
    else $error("single advance length wrong");
  chk_start_len: assert property (
    INSN_START && !ADV_EXT |=> !PIPE_ADV_N [*2])
    else $error("instruction start too short");
  chk_merge_len: assert property (
    INSN_START && ADV_EXT |=> !PIPE_ADV_N [*3])
    else $error("merged advance broken");
  cov_reset: cover property (take && op == 16'h0C40);
  cov_jump: cover property ($rose(PC_LOAD));
  cov_merge: cover property (INSN_START && ADV_EXT);
endmodule
bind debug_cmd_and_pipe_trace dbg_trace_chk #(.RST_HOLD(RST_HOLD)) i_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_REQ(CMD_REQ),
  .CMD_READY(CMD_READY), .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA),
  .STACK_REQ(STACK_REQ), .STACK_DONE(STACK_DONE), .STACK_ERR(STACK_ERR), .HALTED(HALTED),
  .PC_LOAD(PC_LOAD), .SYS_RESET_N(SYS_RESET_N), .FLUSH(FLUSH), .FETCH_CYCLE(FETCH_CYCLE),
  .LOOP_RECIRC(LOOP_RECIRC), .FETCH_IND_N(FETCH_IND_N), .ADV_EXT(ADV_EXT),
  .INSN_START(INSN_START), .PIPE_ADV_N(PIPE_ADV_N));

// File: verification/debug_cmd_and_pipe_trace_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
`define WAIT(s) begin t = 0; while ((s) !== 1'b1 && t < 700) begin @(negedge CORE_CLK); t++; end \
  if (t >= 700) begin errors++; $display("unexpected wait timeout exp 1 got 0"); end end
module debug_cmd_and_pipe_trace_tb;
  import dbg_trace_pkg::*;
  localparam int RH = 4;
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic DEBUG_ENTER = 1'b0, CMD_VALID = 1'b0, FLUSH = 1'b0, FETCH_CYCLE = 1'b0;
  logic ADV_EXT = 1'b0, INSN_START = 1'b0, LOOP_RECIRC = 1'b0, fail = 1'b0;
  logic [3:0] lag = 4'h0;
  cmd_req_t CMD_REQ = '0;
  fetch_done_t FETCH_DONE = '0;
  logic [31:0] RPC_IN = 32'h0000_1234;
  logic [31:0] SP_IN = 32'h0000_8000;
  logic STACK_DONE, STACK_ERR, HALTED, CMD_READY, RESP_VALID, STACK_REQ, PC_LOAD;
  logic EXC_REQ, EXC_ADDR_ERR, SYS_RESET_N, FETCH_IND_N, PIPE_ADV_N, DECODE_VALID;
  logic EXEC_VALID, PREFETCH_ROOM;
  logic [16:0] RESP_DATA;
  logic [31:0] STACK_ADDR, STACK_DATA, PC_VALUE, EXC_FAULT_ADDR;
  logic [15:0] DECODE_WORD, EXEC_WORD;
  wire [34:0] stages = {EXEC_VALID, EXEC_WORD, DECODE_VALID, DECODE_WORD, PREFETCH_ROOM};
  int errors = 0;
  int n_compared = 0;
  int t;
  core_stack_model i_core (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .STACK_REQ(STACK_REQ),
    .fail(fail), .lag(lag), .STACK_DONE(STACK_DONE), .STACK_ERR(STACK_ERR));
  debug_cmd_and_pipe_trace #(.RST_HOLD(RH)) i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .DEBUG_ENTER(DEBUG_ENTER), .HALTED(HALTED), .CMD_VALID(CMD_VALID), .CMD_REQ(CMD_REQ),
    .CMD_READY(CMD_READY), .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA), .RPC_IN(RPC_IN),
    .SP_IN(SP_IN), .STACK_REQ(STACK_REQ), .STACK_ADDR(STACK_ADDR), .STACK_DATA(STACK_DATA),
    .STACK_DONE(STACK_DONE), .STACK_ERR(STACK_ERR), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
    .EXC_REQ(EXC_REQ), .EXC_ADDR_ERR(EXC_ADDR_ERR), .EXC_FAULT_ADDR(EXC_FAULT_ADDR),
    .SYS_RESET_N(SYS_RESET_N), .FLUSH(FLUSH), .FETCH_CYCLE(FETCH_CYCLE),
    .FETCH_DONE(FETCH_DONE), .ADV_EXT(ADV_EXT), .INSN_START(INSN_START),
    .LOOP_RECIRC(LOOP_RECIRC), .FETCH_IND_N(FETCH_IND_N), .PIPE_ADV_N(PIPE_ADV_N),
    .DECODE_WORD(DECODE_WORD), .DECODE_VALID(DECODE_VALID), .EXEC_WORD(EXEC_WORD),
    .EXEC_VALID(EXEC_VALID), .PREFETCH_ROOM(PREFETCH_ROOM));
  always #2.5 CORE_CLK = ~CORE_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task ev(input logic [3:0] v);
    {FLUSH, FETCH_CYCLE, ADV_EXT, INSN_START} = v;
    @(negedge CORE_CLK);
  endtask
  function logic pin(input bit p);
    return p ? PIPE_ADV_N : FETCH_IND_N;
  endfunction
  // Counting runs alongside the stimulus so the first low cycle is never missed.
  task automatic meas(input bit p, input logic [3:0] a, b, c, input int e);
    int n;
    int w;
    n = 0;
    w = 0;
    fork
      begin ev(a); ev(b); ev(c); ev(4'h0); end
      begin
        while (pin(p) !== 1'b0 && w < 5) begin @(negedge CORE_CLK); w++; end
        while (pin(p) === 1'b0 && n < 9) begin @(negedge CORE_CLK); n++; end
      end
    join
    `CHK("pin low cycles", e, n)
  endtask
  task load(input logic [15:0] w);
    FETCH_DONE = {3'h4, w};
    @(negedge CORE_CLK);
    FETCH_DONE = '0;
    repeat (3) @(negedge CORE_CLK);
  endtask
  task cmd(input logic [15:0] op, input logic [31:0] opd);
    @(negedge CORE_CLK);
    CMD_REQ = {op, opd};
    CMD_VALID = 1'b1;
    // Ready is judged at the falling edge, where it has settled, so the request spans the take.
    `WAIT(CMD_READY)
    @(negedge CORE_CLK);
    CMD_VALID = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_pipe;
    load(16'h1111);
    load(16'h2222);
    load(16'h3333);
    `CHK("fill", {17'h11111, 17'h12222, 1'b0}, stages)
    meas(1'b1, 4'h2, 4'h0, 4'h0, 1);
    `CHK("one advance", {17'h11111, 17'h13333, 1'b1}, stages)
    meas(1'b1, 4'h1, 4'h0, 4'h0, 2);
    `CHK("full advance", {17'h13333, 1'b0}, stages[34:17])
    load(16'h4444);
    load(16'h5555);
    meas(1'b1, 4'h3, 4'h0, 4'h0, 3);
    `CHK("both advances", {17'h14444, 1'b0}, stages[34:17])
    $display("done pipe");
  endtask
  task t_fetch;
    meas(1'b0, 4'h4, 4'h0, 4'h0, 1);
    meas(1'b0, 4'h8, 4'h4, 4'h4, 3);
    LOOP_RECIRC = 1'b1;
    meas(1'b0, 4'h4, 4'h0, 4'h0, 0);
    meas(1'b1, 4'h2, 4'h0, 4'h0, 1);
    LOOP_RECIRC = 1'b0;
    meas(1'b0, 4'h4, 4'h0, 4'h0, 1);
    $display("done fetch");
  endtask
  task t_cmds;
    logic [15:0] ops [3];
    int n;
    ops = '{16'h0001, 16'h0C81, 16'hFFFF};
    CMD_VALID = 1'b1;
    repeat (2) begin
      @(negedge CORE_CLK);
      `CHK("nop resp", 18'h2FFFF, {RESP_VALID, RESP_DATA})
    end
    CMD_VALID = 1'b0;
    @(negedge CORE_CLK);
    `CHK("nop quiet", 2'h1, {RESP_VALID, HALTED})
    foreach (ops[i]) begin
      cmd(ops[i], 32'h0000_0000);
      `WAIT(RESP_VALID)
      `CHK("illegal resp", 18'h3FFFF, {HALTED, RESP_DATA})
    end
    cmd(16'h0C40, 32'h0000_0000);
    n = 0;
    `WAIT(~SYS_RESET_N)
    while (SYS_RESET_N === 1'b0 && n < 700) begin @(negedge CORE_CLK); n++; end
    `CHK("reset width", RH, n)
    `WAIT(RESP_VALID)
    `CHK("reset resp", 18'h2FFFF, {HALTED, RESP_DATA})
    $display("done commands");
  endtask
  task t_call(input logic err, input logic [31:0] opd);
    @(negedge CORE_CLK);
    fail = err;
    lag = err ? 4'h5 : 4'h0;
    cmd(16'h0C80, opd);
    `CHK("stack write", {1'b1, SP_IN, RPC_IN}, {STACK_REQ, STACK_ADDR, STACK_DATA})
    if (err) begin
      `WAIT(RESP_VALID)
      `CHK("stack err", 18'h30001, {HALTED, RESP_DATA})
    end else begin
      `WAIT(PC_LOAD)
      `CHK("jump", {2'b00, opd}, {HALTED, RESP_VALID, PC_VALUE})
      repeat (2) @(negedge CORE_CLK);
      meas(1'b0, 4'h4, 4'h0, 4'h0, 2);
      FETCH_DONE = {3'h5, 16'h0000};
      @(negedge CORE_CLK);
      FETCH_DONE = '0;
      `WAIT(EXC_REQ)
      `CHK("exception", {1'b1, opd}, {EXC_ADDR_ERR, EXC_FAULT_ADDR})
    end
    $display("done call");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    errors++;
    test_done;
  end
  initial begin
    repeat (8) @(negedge CORE_CLK);
    RST_N = 1'b1;
    `CHK("reset state", 5'h1E, {PREFETCH_ROOM, FETCH_IND_N, PIPE_ADV_N, SYS_RESET_N, HALTED})
    t_pipe;
    t_fetch;
    DEBUG_ENTER = 1'b1;
    @(negedge CORE_CLK);
    DEBUG_ENTER = 1'b0;
    `WAIT(HALTED)
    CMD_REQ = '0;
    t_cmds;
    t_call(1'b1, 32'h0000_4000);
    t_call(1'b0, 32'h0000_2001);
    test_done;
  end
endmodule
